// ===== bench/cpu_access_model.sv
`timescale 1ns/1ps
module cpu_access_model (
   input wire CLK,
   output reg REQ,
   output reg WE,
   output reg DIRECT,
   output reg [17:0] ADDR,
   output reg [15:0] WDATA,
   output reg FETCH_IN_FLASH,
   output reg IFETCH
);
   initial begin
      REQ = 1'b0;
      WE = 1'b0;
      DIRECT = 1'b0;
      ADDR = 18'h00000;
      WDATA = 16'h0000;
      FETCH_IN_FLASH = 1'b0;
      IFETCH = 1'b0;
   end
   // one access; address and data lines inverted after release so no stale value lingers
   task acc(input w, input d, input [17:0] a, input [15:0] wd, input f, input i);
      begin
         @(posedge CLK);
         REQ <= 1'b1;
         WE <= w;
         DIRECT <= d;
         ADDR <= a;
         WDATA <= wd;
         FETCH_IN_FLASH <= f;
         IFETCH <= i;
         @(posedge CLK);
         REQ <= 1'b0;
         ADDR <= ~a;
         WDATA <= ~wd;
         #1;
      end
   endtask
endmodule

// ===== bench/flash_write_control_assertions.sv
`timescale 1ns/1ps
module flash_write_control_assertions (
   input wire CLK,
   input wire SRST,
   input wire SEG_SELECT,
   input wire INIT_DONE,
   input wire PROTECT_OPTION,
   input wire SUPPLY_OK,
   input wire REQ,
   input wire WE,
   input wire DIRECT,
   input wire [17:0] ADDR,
   input wire [15:0] WDATA,
   input wire FETCH_IN_FLASH,
   input wire IFETCH,
   input wire FLASH_HIT,
   input wire [31:0] RDATA,
   input wire RVALID,
   input wire REFUSED,
   input wire BUSY,
   input wire [1:0] MODE,
   input wire PROTECT_ACTIVE,
   input wire SEGMENT
);
   // ----------------------------------------
   // helper logic
   // ----------------------------------------
   // busy length counted here: a repetition of 128 would be too costly to unroll
   reg [19:0] busy_cnt;
   wire data_blocked;
   wire arr_cmd;
   wire ctrl_side;
   assign data_blocked = PROTECT_ACTIVE && !FETCH_IN_FLASH && !IFETCH;
   assign arr_cmd = REQ && WE && !DIRECT && FLASH_HIT && MODE[1];
   // direct reads in writing mode hit the control word, never the protected array
   assign ctrl_side = DIRECT && (MODE != 2'h0);
   always @(posedge CLK) begin
      if (SRST || !BUSY) begin
         busy_cnt <= 20'h00000;
      end else begin
         busy_cnt <= busy_cnt + 20'h00001;
      end
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SRST);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   hit_decode_a: assert property (FLASH_HIT ==
      (REQ && !ADDR[17] && ADDR[16] == SEGMENT && !ADDR[15]))
      else $error("flash hit decode wrong");
   read_answer_a: assert property (REQ && !WE && FLASH_HIT && !BUSY &&
      !data_blocked |=> RVALID && !REFUSED)
      else $error("accepted read gave no data");
   protect_refuse_a: assert property (REQ && !WE && FLASH_HIT &&
      data_blocked && !ctrl_side |=> REFUSED && !RVALID)
      else $error("protected read not refused");
   busy_refuse_a: assert property (BUSY && REQ && !WE && !DIRECT &&
      FLASH_HIT |=> REFUSED)
      else $error("array read while busy not refused");
   rdata_idle_a: assert property (!RVALID |-> RDATA == 32'h00000000)
      else $error("read data not zero when idle");
   busy_cause_a: assert property ($rose(BUSY) |-> $past(arr_cmd))
      else $error("busy rose without an array write");
   busy_mode_a: assert property (BUSY |-> MODE[1])
      else $error("busy outside program or erase mode");
   pulse_len_a: assert property ($fell(BUSY) |-> busy_cnt >= 20'h00080)
      else $error("pulse shorter than shortest code");
   std_lock_a: assert property (MODE == 2'h0 && REQ && WE && DIRECT |=> MODE == 2'h0)
      else $error("control word took effect in standard mode");
   protect_reset_a: assert property ($fell(SRST) && PROTECT_OPTION |-> PROTECT_ACTIVE)
      else $error("protection not active after reset");
   protect_option_a: assert property (PROTECT_ACTIVE |-> PROTECT_OPTION)
      else $error("protection active without option");
   busy_seen_c: cover property ($rose(BUSY));
   refused_seen_c: cover property (REFUSED);
   erase_mode_c: cover property (MODE == 2'h3);
endmodule

bind flash_write_control flash_write_control_assertions i_chk (.CLK(CLK), .SRST(SRST),
   .SEG_SELECT(SEG_SELECT), .INIT_DONE(INIT_DONE), .PROTECT_OPTION(PROTECT_OPTION),
   .SUPPLY_OK(SUPPLY_OK), .REQ(REQ), .WE(WE), .DIRECT(DIRECT), .ADDR(ADDR), .WDATA(WDATA),
   .FETCH_IN_FLASH(FETCH_IN_FLASH), .IFETCH(IFETCH), .FLASH_HIT(FLASH_HIT), .RDATA(RDATA),
   .RVALID(RVALID), .REFUSED(REFUSED), .BUSY(BUSY), .MODE(MODE),
   .PROTECT_ACTIVE(PROTECT_ACTIVE), .SEGMENT(SEGMENT));

// ===== bench/flash_write_control_test.sv
`timescale 1ns/1ps
module flash_write_control_test;
   typedef struct packed {
      logic w; logic d; logic [17:0] a; logic [15:0] wd; logic f; logic i;
      logic rv; logic rf; logic [31:0] rd; logic p;
   } row_t;
   row_t rows [0:9];
   logic [15:0] mw [4] = '{16'h8000, 16'h8002, 16'h8001, 16'h8003};
   logic [1:0] mm [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
   reg CLK = 1'b0;
   reg SRST = 1'b1;
   reg SEG_SELECT = 1'b1;
   reg INIT_DONE = 1'b0;
   reg PROTECT_OPTION = 1'b1;
   reg SUPPLY_OK = 1'b1;
   wire REQ, WE, DIRECT, FETCH_IN_FLASH, IFETCH, FLASH_HIT, RVALID, REFUSED, BUSY;
   wire PROTECT_ACTIVE, SEGMENT;
   wire [17:0] ADDR;
   wire [15:0] WDATA;
   wire [31:0] RDATA;
   wire [1:0] MODE;
   integer n_mismatch = 0;
   integer cmp_count = 0;
   integer k;
   integer n;
   always #25 CLK = ~CLK;
   cpu_access_model i_cpu (.CLK(CLK), .REQ(REQ), .WE(WE), .DIRECT(DIRECT), .ADDR(ADDR),
      .WDATA(WDATA), .FETCH_IN_FLASH(FETCH_IN_FLASH), .IFETCH(IFETCH));
   flash_write_control i_dut (.CLK(CLK), .SRST(SRST), .SEG_SELECT(SEG_SELECT),
      .INIT_DONE(INIT_DONE), .PROTECT_OPTION(PROTECT_OPTION), .SUPPLY_OK(SUPPLY_OK),
      .REQ(REQ), .WE(WE), .DIRECT(DIRECT), .ADDR(ADDR), .WDATA(WDATA),
      .FETCH_IN_FLASH(FETCH_IN_FLASH), .IFETCH(IFETCH), .FLASH_HIT(FLASH_HIT), .RDATA(RDATA),
      .RVALID(RVALID), .REFUSED(REFUSED), .BUSY(BUSY), .MODE(MODE),
      .PROTECT_ACTIVE(PROTECT_ACTIVE), .SEGMENT(SEGMENT));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task results;
      begin
         $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
         if (n_mismatch == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
         end else begin
            $display("MISMATCHES SEEN");
         end
         $finish;
      end
   endtask
   task cmp(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // counts cycles until busy drops; running out ends the run
   task wait_idle(input integer lim);
      begin
         n = 0;
         while (BUSY !== 1'b0 && n < lim) begin
            @(posedge CLK);
            #1;
            n = n + 1;
         end
         if (BUSY !== 1'b0) begin
            n_mismatch = n_mismatch + 1;
            results;
         end
      end
   endtask
   task ctrl(input [15:0] v);
      i_cpu.acc(1'b1, 1'b1, 18'h17FA0, v, 1'b0, 1'b0);
   endtask
   task rd(input d, input [17:0] a);
      i_cpu.acc(1'b0, d, a, 16'h0000, 1'b0, 1'b0);
   endtask
   task wr(input [17:0] a, input [15:0] v);
      i_cpu.acc(1'b1, 1'b0, a, v, 1'b0, 1'b0);
   endtask
   initial begin
      rows[0] = '{0, 0, 18'h10000, 16'h0000, 1, 0, 1, 0, 32'hFFFFFFFF, 1};
      rows[1] = '{0, 1, 18'h10004, 16'h0000, 0, 0, 0, 1, 32'h00000000, 1};
      rows[2] = '{0, 0, 18'h10008, 16'h0000, 0, 1, 1, 0, 32'hFFFFFFFF, 1};
      rows[3] = '{0, 0, 18'h08000, 16'h0000, 0, 1, 0, 0, 32'h00000000, 1};
      rows[4] = '{1, 1, 18'h17FA0, 16'h0000, 0, 0, 0, 0, 32'h00000000, 1};
      rows[5] = '{1, 1, 18'h17FA0, 16'h0000, 1, 0, 0, 0, 32'h00000000, 0};
      rows[6] = '{0, 1, 18'h17FA0, 16'h0000, 0, 0, 1, 0, 32'hFFFFFFFF, 0};
      rows[7] = '{1, 1, 18'h17FA0, 16'h8003, 0, 0, 0, 0, 32'h00000000, 0};
      rows[8] = '{1, 1, 18'h17FA0, 16'h0004, 1, 0, 0, 0, 32'h00000000, 1};
      rows[9] = '{1, 1, 18'h17FA0, 16'h0000, 1, 0, 0, 0, 32'h00000000, 0};
      repeat (8) @(posedge CLK);
      SRST <= 1'b0;
      repeat (2) @(posedge CLK);
      INIT_DONE <= 1'b1;
      @(posedge CLK);
      SEG_SELECT <= 1'b0;
      repeat (2) @(posedge CLK);
      #1;
      cmp(SEGMENT, 1'b1);
      cmp(BUSY, 1'b0);
      cmp(PROTECT_ACTIVE, 1'b1);
      for (k = 0; k < 10; k = k + 1) begin
         i_cpu.acc(rows[k].w, rows[k].d, rows[k].a, rows[k].wd, rows[k].f, rows[k].i);
         cmp(RVALID, rows[k].rv);
         cmp(REFUSED, rows[k].rf);
         cmp(RDATA, rows[k].rd);
         cmp(PROTECT_ACTIVE, rows[k].p);
         cmp(MODE, 2'h0);
      end
      // ----------------------------------------
      // unlock and mode selection
      // ----------------------------------------
      ctrl(16'h0000);
      wr(18'h10040, 16'h0040);
      cmp(MODE, 2'h1);
      rd(1'b1, 18'h17FA0);
      cmp(RDATA[15:0], 16'h8010);
      for (k = 0; k < 4; k = k + 1) begin
         ctrl(mw[k]);
         cmp(MODE, mm[k]);
         cmp(BUSY, 1'b0);
      end
      // ----------------------------------------
      // word and double word programming
      // ----------------------------------------
      ctrl(16'h8001);
      wr(18'h10010, 16'h1234);
      cmp(BUSY, 1'b1);
      wait_idle(300);
      cmp(n, 128);
      rd(1'b0, 18'h10010);
      cmp(RDATA, 32'hFFFF1234);
      ctrl(16'h8081);
      wr(18'h13000, 16'hAAAA);
      cmp(BUSY, 1'b0);
      wr(18'h13000, 16'h5555);
      cmp(BUSY, 1'b1);
      wait_idle(300);
      wr(18'h10031, 16'h0031);
      cmp(REFUSED, 1'b1);
      // ----------------------------------------
      // erase bank 0 with a supply drop, then bank 3
      // ----------------------------------------
      ctrl(16'h8003);
      wr(18'h10010, 16'h1111);
      cmp(BUSY, 1'b0);
      wr(18'h10010, 16'h0010);
      cmp(BUSY, 1'b1);
      rd(1'b0, 18'h10000);
      cmp(REFUSED, 1'b1);
      SUPPLY_OK <= 1'b0;
      rd(1'b1, 18'h17FA0);
      cmp(RDATA[2], 1'b1);
      wait_idle(4000);
      SUPPLY_OK <= 1'b1;
      repeat (4) @(posedge CLK);
      rd(1'b1, 18'h17FA0);
      cmp(RDATA[4:3], 2'h3);
      rd(1'b0, 18'h10010);
      cmp(RDATA, 32'hFFFFFFFF);
      rd(1'b0, 18'h13000);
      cmp(RDATA, 32'h5555AAAA);
      ctrl(16'h8303);
      wr(18'h17800, 16'h7800);
      wait_idle(4000);
      cmp(n >= 500 && n <= 530, 1'b1);
      ctrl(16'h0000);
      cmp(MODE, 2'h0);
      rd(1'b1, 18'h17FA0);
      cmp(RDATA, 32'hFFFFFFFF);
      // ----------------------------------------
      // protection option off, then reset in mid-run
      // ----------------------------------------
      @(posedge CLK);
      PROTECT_OPTION <= 1'b0;
      i_cpu.acc(1'b1, 1'b1, 18'h17FA0, 16'h0004, 1'b1, 1'b0);
      @(posedge CLK);
      PROTECT_OPTION <= 1'b1;
      #1;
      cmp(PROTECT_ACTIVE, 1'b0);
      @(posedge CLK);
      SRST <= 1'b1;
      repeat (2) @(posedge CLK);
      #1;
      cmp(PROTECT_ACTIVE, 1'b1);
      cmp(SEGMENT, 1'b0);
      cmp(MODE, 2'h0);
      cmp(RVALID | REFUSED | BUSY, 1'b0);
      @(posedge CLK);
      SRST <= 1'b0;
      repeat (2) @(posedge CLK);
      #1;
      cmp(SEGMENT, 1'b0);
      results;
   end
endmodule

// ===== src/flash_array_store.v
`timescale 1ns/1ps
`include "flash_write_control_map.vh"

module flash_array_store #(
   parameter ADDR_W = 13,
   parameter DATA_W = 32
) (
   input wire clk,
   input wire wr_en,
   input wire [ADDR_W-1:0] wr_addr,
   input wire [DATA_W-1:0] wr_data,
   input wire [DATA_W-1:0] wr_mask,
   input wire [ADDR_W-1:0] rd_addr,
   output reg [DATA_W-1:0] rd_data
);

   reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   integer i;

   // ----------------------------------------
   // array starts erased
   // ----------------------------------------
   initial begin
      for (i = 0; i < (1<<ADDR_W); i = i + 1) begin
         mem[i] = `FWC_ERASED_WORD;
      end
   end

   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
      end
      rd_data <= mem[rd_addr];
   end

endmodule

// ===== src/flash_write_control.v
`timescale 1ns/1ps
`include "flash_write_control_map.vh"

// What this block does
// - array sits in segment 0 or 1, fixed at init
// - array is 8K entries of 32 bits
// - four erase banks of 12/12/6/2 KByte
// - erased locations read as all ones
// - protection refuses data reads from code outside flash
// - control word locked until key sequence enters writing
// - writing mode: direct to control, indirect to array
// - mode decoded from hold, erase, write enable bits
// - mode bits select only, never start operations
// - busy set by command, clear when idle
// - protect bit write-only, writable from flash code only
// - protect resets to one, acts only when option enabled
// - supply valid flag shows programming supply level
// - supply fault set if supply drops during operation
// - pulse width 2^7/2^11/2^15/2^18 clocks per code
// - double word bit picks 16 or 32 bit programming
// - bank field picks erased bank in erase mode
// - erase starts on write whose data equals address
// - 32-bit programming starts on second same-address write
// - bank codes 0 to 3 map to banks 0 to 3

module flash_write_control #(
   parameter ENTRY_W = 13,
   parameter PULSE_W = 19
) (
   input wire CLK,
   input wire SRST,
   input wire SEG_SELECT,
   input wire INIT_DONE,
   input wire PROTECT_OPTION,
   input wire SUPPLY_OK,
   input wire REQ,
   input wire WE,
   input wire DIRECT,
   input wire [17:0] ADDR,
   input wire [15:0] WDATA,
   input wire FETCH_IN_FLASH,
   input wire IFETCH,
   output wire FLASH_HIT,
   output reg [31:0] RDATA,
   output reg RVALID,
   output reg REFUSED,
   output wire BUSY,
   output wire [1:0] MODE,
   output wire PROTECT_ACTIVE,
   output wire SEGMENT
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg seg_reg;
   reg init_done_reg;
   reg hold_reg;
   reg erase_reg;
   reg wren_reg;
   reg dword_reg;
   reg [1:0] pw_reg;
   reg [1:0] bank_reg;
   reg protect_reg;
   reg fault_reg;
   reg busy_reg;
   reg armed_reg;
   reg dw_pending_reg;
   reg [ENTRY_W-1:0] dw_entry_reg;
   reg [15:0] dw_low_reg;
   reg [PULSE_W-1:0] pulse_reg;
   reg walking_reg;
   reg [ENTRY_W-1:0] walk_ptr_reg;
   reg [ENTRY_W-1:0] walk_end_reg;
   reg supply_meta_reg;
   reg supply_reg;
   reg [1:0] rsel_reg;
   reg [15:0] ctrl_rd_reg;

   wire [31:0] mem_rd;
   reg mem_we;
   reg [ENTRY_W-1:0] mem_waddr;
   reg [31:0] mem_wdata;
   reg [31:0] mem_wmask;
   reg [PULSE_W-1:0] pulse_load;
   reg [ENTRY_W-1:0] bank_first;
   reg [ENTRY_W-1:0] bank_last;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   // supply sense is analog-side, so it is synchronised first
   always @(posedge CLK) begin
      supply_meta_reg <= SUPPLY_OK;
      supply_reg <= supply_meta_reg;
   end

   wire in_range = (ADDR[17:16] == {1'b0, seg_reg}) && !ADDR[15];
   wire [ENTRY_W-1:0] entry = ADDR[ENTRY_W+1:2];
   wire hit = REQ && in_range;
   wire protected_now = protect_reg && PROTECT_OPTION;
   wire writing = hold_reg;
   wire [1:0] mode = !hold_reg ? `FWC_MODE_STANDARD :
                     !wren_reg ? `FWC_MODE_NONVERIFY :
                     erase_reg ? `FWC_MODE_ERASE : `FWC_MODE_PROGRAM;
   wire ctrl_wr = hit && WE && DIRECT && writing && !ADDR[0];
   wire ctrl_rd = hit && !WE && DIRECT && writing;
   wire arr_wr = hit && WE && !DIRECT && writing && !ADDR[0];
   wire key_match = (WDATA == ADDR[15:0]) && !ADDR[0];
   wire dw_second = dw_pending_reg && (dw_entry_reg == entry);
   wire start_erase = arr_wr && !busy_reg && (mode == `FWC_MODE_ERASE) && key_match;
   wire start_word = arr_wr && !busy_reg && (mode == `FWC_MODE_PROGRAM) && !dword_reg;
   wire start_dword = arr_wr && !busy_reg && (mode == `FWC_MODE_PROGRAM) && dword_reg &&
                      dw_second;
   wire start_op = start_erase || start_word || start_dword;
   // data reads from outside the flash are refused under protection; array busy too
   wire arr_rd = hit && !WE && !ctrl_rd;
   wire rd_refuse = arr_rd && (busy_reg || (protected_now && !FETCH_IN_FLASH && !IFETCH));
   wire wr_refuse = hit && WE && !ctrl_wr && !arr_wr && writing;
   wire pulse_done = (pulse_reg == {PULSE_W{1'b0}});

   always @* begin
      case (pw_reg)
         2'h0: pulse_load = (({{(PULSE_W-1){1'b0}}, 1'b1}) << `FWC_PW_SHIFT0) - 1'b1;
         2'h1: pulse_load = (({{(PULSE_W-1){1'b0}}, 1'b1}) << `FWC_PW_SHIFT1) - 1'b1;
         2'h2: pulse_load = (({{(PULSE_W-1){1'b0}}, 1'b1}) << `FWC_PW_SHIFT2) - 1'b1;
         default: pulse_load = (({{(PULSE_W-1){1'b0}}, 1'b1}) << `FWC_PW_SHIFT3) - 1'b1;
      endcase
   end

   always @* begin
      case (bank_reg)
         2'h0: begin
            bank_first = `FWC_BANK0_FIRST;
            bank_last = `FWC_BANK0_LAST;
         end
         2'h1: begin
            bank_first = `FWC_BANK1_FIRST;
            bank_last = `FWC_BANK1_LAST;
         end
         2'h2: begin
            bank_first = `FWC_BANK2_FIRST;
            bank_last = `FWC_BANK2_LAST;
         end
         default: begin
            bank_first = `FWC_BANK3_FIRST;
            bank_last = `FWC_BANK3_LAST;
         end
      endcase
   end

   // ----------------------------------------
   // array write port
   // ----------------------------------------
   // erase walks one entry a clock; a short pulse code stretches busy to the walk
   always @* begin
      mem_we = 1'b0;
      mem_waddr = entry;
      mem_wdata = {WDATA, WDATA};
      mem_wmask = 32'h00000000;
      if (walking_reg) begin
         mem_we = 1'b1;
         mem_waddr = walk_ptr_reg;
         mem_wdata = `FWC_ERASED_WORD;
         mem_wmask = 32'hFFFFFFFF;
      end else if (start_dword) begin
         mem_we = 1'b1;
         mem_wdata = {WDATA, dw_low_reg};
         mem_wmask = 32'hFFFFFFFF;
      end else if (start_word) begin
         mem_we = 1'b1;
         mem_wmask = ADDR[1] ? 32'hFFFF0000 : 32'h0000FFFF;
      end
   end

   flash_array_store #(
      .ADDR_W(ENTRY_W),
      .DATA_W(32)
   ) u_store (
      .clk(CLK),
      .wr_en(mem_we),
      .wr_addr(mem_waddr),
      .wr_data(mem_wdata),
      .wr_mask(mem_wmask),
      .rd_addr(entry),
      .rd_data(mem_rd)
   );

   // ----------------------------------------
   // mapping and control word
   // ----------------------------------------
   always @(posedge CLK) begin
      if (SRST) begin
         seg_reg <= 1'b0;
         init_done_reg <= 1'b0;
      end else if (!init_done_reg) begin
         seg_reg <= SEG_SELECT;
         init_done_reg <= INIT_DONE;
      end
   end

   always @(posedge CLK) begin
      if (SRST) begin
         hold_reg <= `FWC_RESET_HOLD;
         erase_reg <= 1'b0;
         wren_reg <= 1'b0;
         dword_reg <= 1'b0;
         pw_reg <= `FWC_RESET_PW;
         bank_reg <= `FWC_RESET_BANK;
         protect_reg <= `FWC_RESET_PROTECT;
         armed_reg <= 1'b0;
      end else begin
         if (hit) begin
            armed_reg <= !writing && WE && DIRECT && !ADDR[0];
         end
         if (!writing && armed_reg && hit && WE && !DIRECT && key_match) begin
            hold_reg <= 1'b1;
         end
         // locked outside writing mode; mode fields frozen while a pulse runs
         if (ctrl_wr && !busy_reg) begin
            hold_reg <= WDATA[`FWC_HOLD_BIT];
            bank_reg <= WDATA[`FWC_BANK_HI:`FWC_BANK_LO];
            dword_reg <= WDATA[`FWC_DWORD_BIT];
            pw_reg <= WDATA[`FWC_PW_HI:`FWC_PW_LO];
            erase_reg <= WDATA[`FWC_ERASE_BIT];
            wren_reg <= WDATA[`FWC_WREN_BIT];
         end
         if (hit && WE && DIRECT && !ADDR[0] && FETCH_IN_FLASH && PROTECT_OPTION) begin
            protect_reg <= WDATA[`FWC_BUSY_BIT];
         end
      end
   end

   // ----------------------------------------
   // operation sequencing
   // ----------------------------------------
   always @(posedge CLK) begin
      if (SRST) begin
         busy_reg <= 1'b0;
         fault_reg <= 1'b0;
         pulse_reg <= {PULSE_W{1'b0}};
         walking_reg <= 1'b0;
         walk_ptr_reg <= {ENTRY_W{1'b0}};
         walk_end_reg <= {ENTRY_W{1'b0}};
         dw_pending_reg <= 1'b0;
         dw_entry_reg <= {ENTRY_W{1'b0}};
         dw_low_reg <= 16'h0000;
      end else begin
         if (start_op) begin
            busy_reg <= 1'b1;
            fault_reg <= !supply_reg;
            pulse_reg <= pulse_load;
            dw_pending_reg <= 1'b0;
         end else begin
            if (!pulse_done) begin
               pulse_reg <= pulse_reg - 1'b1;
            end
            if (busy_reg && pulse_done && !walking_reg) begin
               busy_reg <= 1'b0;
            end
            if (busy_reg && !supply_reg) begin
               fault_reg <= 1'b1;
            end
            if (hit) begin
               dw_pending_reg <= arr_wr && !busy_reg && (mode == `FWC_MODE_PROGRAM) &&
                                 dword_reg && !ADDR[1];
               dw_entry_reg <= entry;
               dw_low_reg <= WDATA;
            end
         end
         if (start_erase) begin
            walking_reg <= 1'b1;
            walk_ptr_reg <= bank_first;
            walk_end_reg <= bank_last;
         end else if (walking_reg) begin
            walk_ptr_reg <= walk_ptr_reg + 1'b1;
            if (walk_ptr_reg == walk_end_reg) begin
               walking_reg <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // read answer
   // ----------------------------------------
   always @(posedge CLK) begin
      if (SRST) begin
         RVALID <= 1'b0;
         REFUSED <= 1'b0;
         rsel_reg <= 2'h0;
         ctrl_rd_reg <= 16'h0000;
      end else begin
         RVALID <= hit && !WE && !rd_refuse;
         REFUSED <= rd_refuse || wr_refuse;
         rsel_reg <= {ctrl_rd, arr_rd && !rd_refuse};
         ctrl_rd_reg <= {hold_reg, 5'h00, bank_reg, dword_reg, pw_reg,
                         supply_reg, fault_reg, busy_reg, erase_reg, wren_reg};
      end
   end

   always @* begin
      case (rsel_reg)
         2'h1: RDATA = mem_rd;
         2'h2: RDATA = {16'h0000, ctrl_rd_reg};
         default: RDATA = 32'h00000000;
      endcase
   end

   assign FLASH_HIT = hit;
   assign BUSY = busy_reg;
   assign MODE = mode;
   assign PROTECT_ACTIVE = protected_now;
   assign SEGMENT = seg_reg;

endmodule

// ===== src/flash_write_control_map.vh
`ifndef FLASH_WRITE_CONTROL_MAP_VH
`define FLASH_WRITE_CONTROL_MAP_VH

// ----------------------------------------
// control word layout
// ----------------------------------------
`define FWC_OFFSET 16'hFFA0
`define FWC_HOLD_BIT 15
`define FWC_BANK_HI 9
`define FWC_BANK_LO 8
`define FWC_DWORD_BIT 7
`define FWC_PW_HI 6
`define FWC_PW_LO 5
`define FWC_VALID_BIT 4
`define FWC_FAULT_BIT 3
`define FWC_BUSY_BIT 2
`define FWC_ERASE_BIT 1
`define FWC_WREN_BIT 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define FWC_RESET_HOLD 1'b0
`define FWC_RESET_BANK 2'h0
`define FWC_RESET_PW 2'h0
`define FWC_RESET_PROTECT 1'b1
`define FWC_ERASED_WORD 32'hFFFFFFFF

// ----------------------------------------
// pulse width as a power of two of clock periods
// ----------------------------------------
`define FWC_PW_SHIFT0 7
`define FWC_PW_SHIFT1 11
`define FWC_PW_SHIFT2 15
`define FWC_PW_SHIFT3 18

// ----------------------------------------
// bank bounds, in 32-bit entries
// ----------------------------------------
`define FWC_BANK0_FIRST 13'h0000
`define FWC_BANK0_LAST 13'h0BFF
`define FWC_BANK1_FIRST 13'h0C00
`define FWC_BANK1_LAST 13'h17FF
`define FWC_BANK2_FIRST 13'h1800
`define FWC_BANK2_LAST 13'h1DFF
`define FWC_BANK3_FIRST 13'h1E00
`define FWC_BANK3_LAST 13'h1FFF

// ----------------------------------------
// operating modes
// ----------------------------------------
`define FWC_MODE_STANDARD 2'h0
`define FWC_MODE_NONVERIFY 2'h1
`define FWC_MODE_PROGRAM 2'h2
`define FWC_MODE_ERASE 2'h3

`endif
